// ===== hw/ctbs_can_tx_buffer_scheduler.v
// Transmit buffer store and scheduler: three buffers, priority pick,
// timestamps, abort handling. Assumes a frame engine that asks for a
// buffer at each arbitration attempt and reports the outcome.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "ctbs_defines.vh"

module ctbs_can_tx_buffer_scheduler (
	input wire clk, // 100 MHz clock
	input wire reset, // Synchronous, active high
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [11:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output wire pready, // APB ready
	output reg [31:0] prdata, // APB read data
	output wire pslverr, // APB error, unmapped address
	input wire bitTick, // One pulse per CAN bit time
	input wire arbStart, // Pulse just before SOF
	output reg txValid, // A buffer is granted for this frame
	output reg [1:0] txIndex, // Granted buffer
	output reg [3:0] txByteCount, // Data bytes to send
	input wire [3:0] txByteAddr, // Engine reads this message byte
	output reg [7:0] txByte, // Message byte of granted buffer
	input wire txDone, // Pulse: valid EOF sent
	input wire txFail, // Pulse: error or lost arbitration
	output wire txIrq, // Transmit interrupt level
	output wire initMode // Initialization mode active
);

	// ****************************************
	// Storage and state
	// ****************************************
	reg [7:0] msgMem [0:(`CTBS_NBUF*16)-1];
	reg [7:0] localPri_q [0:`CTBS_NBUF-1];
	reg [15:0] stamp_q [0:`CTBS_NBUF-1];
	reg [2:0] txEmpty_q;
	reg [2:0] txEmpty_d;
	reg [2:0] irqMask_q;
	reg [2:0] abortReq_q;
	reg [2:0] abortReq_d;
	reg [2:0] abortAck_q;
	reg [2:0] abortAck_d;
	reg [2:0] bufSel_q;
	reg [1:0] ctrl_q;
	reg [15:0] timer_q;
	reg busy_q;
	reg [1:0] active_q;
	reg [1:0] selIdx;
	reg [2:0] firstEmpty;
	reg [7:0] bestRank;
	reg selFound;
	integer i;
	integer j;

	// ****************************************
	// Address decode
	// ****************************************
	// One register per word; byte address is four times the index
	wire [9:0] idx = paddr[11:2];
	wire wrEn = psel & penable & pwrite;
	wire rdEn = psel & ~penable & ~pwrite;
	wire [1:0] fgIdx = bufSel_q[0] ? 2'h0 : (bufSel_q[1] ? 2'h1 : 2'h2);
	wire fgOk = |(bufSel_q & txEmpty_q);
	wire isMsg = (idx >= {2'h0, `CTBS_IDX_MSG}) &&
		(idx < {2'h0, `CTBS_IDX_MSG} + `CTBS_MSG_BYTES);
	wire [3:0] msgOff = idx[3:0];
	wire [5:0] fgAddr = {fgIdx, msgOff};
	wire [5:0] engAddr = {active_q, txByteAddr};
	wire [2:0] reqs = pwdata[2:0] & txEmpty_q;
	wire mapped = isMsg || idx == {2'h0, `CTBS_IDX_TS_HIGH} ||
		idx == {2'h0, `CTBS_IDX_TS_LOW} ||
		idx == {2'h0, `CTBS_IDX_PRIORITY} ||
		idx == {2'h0, `CTBS_IDX_TXE} || idx == {2'h0, `CTBS_IDX_TIE} ||
		idx == {2'h0, `CTBS_IDX_ABORT_REQ} ||
		idx == {2'h0, `CTBS_IDX_ABORT_ACK} ||
		idx == {2'h0, `CTBS_IDX_BSEL} || idx == {2'h0, `CTBS_IDX_CTRL};
	// Remote flag and length code of the buffer about to be granted
	wire grantRemote = msgMem[{selIdx, 4'h3}][0];
	wire [3:0] grantDlc = msgMem[{selIdx, 4'hc}][3:0];

	// ****************************************
	// Bus and status outputs
	// ****************************************
	// Zero wait states: every access phase completes at once
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign initMode = ctrl_q[`CTBS_CTRL_INIT];
	assign txIrq = |(txEmpty_q & irqMask_q);

	// ****************************************
	// Priority selection
	// ****************************************
	always @*
	begin
		selFound = 1'b0;
		selIdx = 2'h0;
		bestRank = 8'hff;
		// Strict less-than keeps the lower index on ties
		// Abort-pending buffers sit out the selection
		for (i = 0; i < `CTBS_NBUF; i = i + 1)
		begin
			if (!txEmpty_q[i] && !abortReq_q[i] &&
				(!selFound || localPri_q[i] < bestRank))
			begin
				selFound = 1'b1;
				selIdx = i[1:0];
				bestRank = localPri_q[i];
			end
		end
		firstEmpty = reqs & (~reqs + 3'h1);
	end

	// ****************************************
	// Flags, abort and completion
	// ****************************************
	always @*
	begin
		txEmpty_d = txEmpty_q;
		abortReq_d = abortReq_q;
		abortAck_d = abortAck_q;
		if (wrEn && idx == {2'h0, `CTBS_IDX_TXE})
			txEmpty_d = txEmpty_q & pwdata[2:0];
		if (wrEn && idx == {2'h0, `CTBS_IDX_ABORT_REQ})
			abortReq_d = (abortReq_q | pwdata[2:0]) & ~txEmpty_q;
		// Hardware sets come last, so they win over a software clear
		for (j = 0; j < `CTBS_NBUF; j = j + 1)
		begin
			// Software clearing empty flag starts a fresh message
			if (wrEn && idx == {2'h0, `CTBS_IDX_TXE} && !pwdata[j])
				abortAck_d[j] = 1'b0;
			// Abort only when not on the bus
			if (abortReq_q[j] && !txEmpty_q[j] &&
				!(busy_q && active_q == j[1:0]))
			begin
				abortAck_d[j] = 1'b1;
				txEmpty_d[j] = 1'b1;
				abortReq_d[j] = 1'b0;
			end
		end
		if (busy_q && txDone)
		begin
			txEmpty_d[active_q] = 1'b1;
			abortAck_d[active_q] = 1'b0;
			abortReq_d[active_q] = 1'b0;
		end
	end

	// ****************************************
	// Flag and control registers
	// ****************************************
	always @(posedge clk)
	begin
		if (reset)
		begin
			txEmpty_q <= `CTBS_TXE_RESET;
			irqMask_q <= 3'h0;
			abortReq_q <= 3'h0;
			abortAck_q <= 3'h0;
			bufSel_q <= 3'h0;
			ctrl_q <= `CTBS_CTRL_RESET;
		end
		else
		begin
			txEmpty_q <= txEmpty_d;
			abortReq_q <= abortReq_d;
			abortAck_q <= abortAck_d;
			if (wrEn && idx == {2'h0, `CTBS_IDX_TIE})
				irqMask_q <= pwdata[2:0];
			if (wrEn && idx == {2'h0, `CTBS_IDX_CTRL})
				ctrl_q <= pwdata[1:0];
			if (wrEn && idx == {2'h0, `CTBS_IDX_BSEL})
				bufSel_q <= firstEmpty;
		end
	end

	// ****************************************
	// Timestamp timer
	// ****************************************
	// Wraps silently; no overflow indication is kept
	always @(posedge clk)
	begin
		if (reset)
			timer_q <= 16'h0000;
		else if (initMode)
			timer_q <= 16'h0000;
		else if (bitTick)
			timer_q <= timer_q + 16'h0001;
	end

	// ****************************************
	// Grant to the frame engine
	// ****************************************
	always @(posedge clk)
	begin
		if (reset)
		begin
			busy_q <= 1'b0;
			active_q <= 2'h0;
			txValid <= 1'b0;
			txIndex <= 2'h0;
			txByteCount <= 4'h0;
		end
		else
		begin
			// Each attempt, retries included, chooses afresh
			if (arbStart && !initMode && selFound)
			begin
				busy_q <= 1'b1;
				active_q <= selIdx;
				txValid <= 1'b1;
				txIndex <= selIdx;
				if (grantRemote)
					txByteCount <= 4'h0;
				else if (grantDlc > `CTBS_DLC_MAX)
					txByteCount <= `CTBS_DLC_MAX;
				else
					txByteCount <= grantDlc;
			end
			else if (busy_q && (txDone || txFail || initMode))
			begin
				busy_q <= 1'b0;
				txValid <= 1'b0;
			end
		end
	end

	// Buffer contents carry no reset, as in the register map
	always @(posedge clk)
	begin
		txByte <= msgMem[engAddr];
		if (busy_q && txDone && ctrl_q[`CTBS_CTRL_TIME])
			stamp_q[active_q] <= timer_q;
		if (wrEn && fgOk && isMsg)
			msgMem[fgAddr] <= pwdata[7:0];
		if (wrEn && fgOk && idx == {2'h0, `CTBS_IDX_PRIORITY})
			localPri_q[fgIdx] <= pwdata[7:0];
	end

	// ****************************************
	// Register read
	// ****************************************
	always @(posedge clk)
	begin
		if (reset)
			prdata <= 32'h00000000;
		else if (rdEn)
		begin
			// Window reads return zero unless the selected buffer is empty
			prdata <= 32'h00000000;
			if (isMsg && fgOk)
				prdata[7:0] <= msgMem[fgAddr];
			else if (idx == {2'h0, `CTBS_IDX_PRIORITY} && fgOk)
				prdata[7:0] <= localPri_q[fgIdx];
			else if (idx == {2'h0, `CTBS_IDX_TS_HIGH} && fgOk)
				prdata[7:0] <= stamp_q[fgIdx][7:0];
			else if (idx == {2'h0, `CTBS_IDX_TS_LOW} && fgOk)
				prdata[7:0] <= stamp_q[fgIdx][15:8];
			else if (idx == {2'h0, `CTBS_IDX_TXE})
				prdata[2:0] <= txEmpty_q;
			else if (idx == {2'h0, `CTBS_IDX_TIE})
				prdata[2:0] <= irqMask_q;
			else if (idx == {2'h0, `CTBS_IDX_ABORT_REQ})
				prdata[2:0] <= abortReq_q;
			else if (idx == {2'h0, `CTBS_IDX_ABORT_ACK})
				prdata[2:0] <= abortAck_q;
			else if (idx == {2'h0, `CTBS_IDX_BSEL})
				prdata[2:0] <= bufSel_q;
			else if (idx == {2'h0, `CTBS_IDX_CTRL})
				prdata[1:0] <= ctrl_q;
		end
	end

endmodule

// ===== hw/ctbs_defines.vh
// Constants for the CAN transmit buffer scheduler: offsets, fields, resets.
// Assumes an APB slave with 32-bit words; byte address = 4 * index.
`ifndef CTBS_DEFINES_VH
`define CTBS_DEFINES_VH

// Printed register indices (not all multiples of four)
`define CTBS_IDX_TS_HIGH 8'h3e
`define CTBS_IDX_TS_LOW 8'h3f
// Chosen register indices
`define CTBS_IDX_PRIORITY 8'h3d
`define CTBS_IDX_TXE 8'h06
`define CTBS_IDX_TIE 8'h07
`define CTBS_IDX_ABORT_REQ 8'h08
`define CTBS_IDX_ABORT_ACK 8'h09
`define CTBS_IDX_BSEL 8'h0a
`define CTBS_IDX_CTRL 8'h0b
`define CTBS_IDX_MSG 8'h20
`define CTBS_MSG_BYTES 13
`define CTBS_DLC_BYTE 12
`define CTBS_RTR_BYTE 3
`define CTBS_DLC_MAX 4'h8
// Control register fields
`define CTBS_CTRL_INIT 0
`define CTBS_CTRL_TIME 1
`define CTBS_CTRL_RESET 2'h1
`define CTBS_TXE_RESET 3'h7
`define CTBS_NBUF 3

`endif

// ===== sim/ctbs_checker_sva.sv
// Checker for the grant and bus outputs of the scheduler.
// Assumes a bind from the bench top; one clock domain.
`timescale 1ns/1ps
module ctbs_checker_sva (
	input wire clk, // Clock
	input wire reset, // Reset
	input wire pslverr, // Error
	input wire arbStart, // Start
	input wire txValid, // Grant
	input wire [1:0] txIndex, // Buffer
	input wire [3:0] txByteCount, // Bytes
	input wire txDone, // Done
	input wire txFail, // Fail
	input wire initMode // Init
);
	// ****
	// Properties
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_grant_cause: assert property ($rose(txValid) |-> $past(arbStart))
		else $error("grant without start");
	a_count_max: assert property (txValid |-> txByteCount <= 4'h8)
		else $error("byte count above eight");
	a_index_range: assert property (txValid |-> txIndex != 2'h3)
		else $error("no such buffer");
	a_done_release: assert property (txValid && txDone |=> !txValid)
		else $error("grant held after done");
	a_fail_release: assert property (txValid && txFail |=> !txValid)
		else $error("grant held after fail");
	a_index_hold: assert property (txValid ##1 txValid |-> $stable(txIndex))
		else $error("buffer changed mid frame");
	a_count_hold: assert property (txValid [*2] |-> $stable(txByteCount))
		else $error("count changed mid frame");
	a_init_idle: assert property (initMode ##1 initMode |-> !txValid)
		else $error("grant in init mode");
	c_done: cover property (txValid && txDone);
	c_fail: cover property (txValid && txFail);
	c_err: cover property (pslverr);
endmodule

// ===== sim/ctbs_engine_model.sv
// Frame engine model facing the scheduler link side.
// Assumes the bench calls send_frame; one clock domain.
`timescale 1ns/1ps
module ctbs_engine_model (
	input wire clk, // Clock
	input wire txValid, // Grant
	input wire [1:0] txIndex, // Buffer
	input wire [3:0] txByteCount, // Bytes
	input wire [7:0] txByte, // Byte
	output logic arbStart, // Start
	output logic [3:0] txByteAddr, // Address
	output logic txDone, // Done
	output logic txFail, // Fail
	output logic bitTick // Bit pulse
);
	logic [7:0] bytes [13];
	logic [1:0] gotIdx;
	logic [3:0] gotCnt;
	initial {arbStart, txByteAddr, txDone, txFail, bitTick} = 0;
	always @(posedge clk) bitTick <= !bitTick;
	// ****
	// One attempt: start, byte reads, outcome
	// ****
	task send_frame(input logic fail);
		@(posedge clk) arbStart <= 1'b1;
		@(posedge clk) arbStart <= 1'b0;
		for (int i = 0; i < 15; i++)
		begin
			@(posedge clk) txByteAddr <= 4'(i);
			// Grant registers are visible one edge after the start pulse
			if (i == 0)
			begin
				gotIdx = txValid ? txIndex : 2'h3;
				gotCnt = txByteCount;
			end
			if (i > 1) bytes[i - 2] = txByte;
		end
		@(posedge clk) {txDone, txFail} <= fail ? 2'b01 : 2'b10;
		@(posedge clk) {txDone, txFail} <= 2'b00;
	endtask
endmodule

// ===== sim/tb_can_tx_buffer_scheduler.sv
// Bench for the scheduler: APB tasks and frame scenarios.
// Assumes the engine model answers each grant.
`timescale 1ns/1ps
`include "ctbs_defines.vh"
module tb_can_tx_buffer_scheduler;
	logic clk, reset, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [1:0] txIndex;
	logic [3:0] txByteCount, txByteAddr;
	logic [7:0] txByte;
	logic [15:0] t0, t1;
	logic txValid, arbStart, txDone, txFail, bitTick, txIrq, initMode;
	int num_errors, check_count;
	ctbs_can_tx_buffer_scheduler dut (.*);
	ctbs_engine_model eng (.*);
	initial
	begin
		clk = 0;
		forever #5 clk = !clk;
	end
	// ****
	// Tasks
	// ****
	task stop_test;
		if (num_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, 2'h0, idx, 2'h0, d};
		@(posedge clk) penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task rd(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 0);
		chk(rdat, exp);
	endtask
	task load(input int b, input logic [7:0] pr, rtr, dlc);
		apb(1'b1, `CTBS_IDX_BSEL, 1 << b);
		rd(`CTBS_IDX_BSEL, 1 << b);
		apb(1'b1, `CTBS_IDX_MSG + 3, rtr);
		apb(1'b1, `CTBS_IDX_MSG + 4, 8'ha0 + pr);
		apb(1'b1, `CTBS_IDX_MSG + 12, dlc);
		apb(1'b1, `CTBS_IDX_PRIORITY, pr);
		rd(`CTBS_IDX_PRIORITY, pr);
		apb(1'b1, `CTBS_IDX_TXE, ~(1 << b));
	endtask
	task frame(input logic fail, input logic [1:0] idx, input logic [3:0] n);
		eng.send_frame(fail);
		chk(eng.gotIdx, idx);
		chk(eng.gotCnt, n);
	endtask
	task stamp(input int b, output logic [15:0] t);
		apb(1'b1, `CTBS_IDX_BSEL, 1 << b);
		apb(1'b0, `CTBS_IDX_TS_LOW, 0);
		t[15:8] = rdat[7:0];
		apb(1'b0, `CTBS_IDX_TS_HIGH, 0);
		t[7:0] = rdat[7:0];
	endtask
	// ****
	// Scenarios
	// ****
	initial
	begin
		reset = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = 0;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		rd(`CTBS_IDX_TXE, 7);
		rd(`CTBS_IDX_CTRL, 1);
		rd(8'h01, 0);
		chk(err, 1);
		apb(1'b1, `CTBS_IDX_CTRL, 2);
		load(0, 5, 0, 8);
		load(1, 3, 0, 2);
		load(2, 3, 1, 5);
		frame(1'b1, 1, 2);
		frame(1'b0, 1, 2);
		chk(eng.bytes[4], 8'ha3);
		frame(1'b0, 2, 0);
		frame(1'b0, 0, 8);
		rd(`CTBS_IDX_TXE, 7);
		rd(`CTBS_IDX_ABORT_ACK, 0);
		stamp(1, t1);
		stamp(0, t0);
		chk(t0 > t1, 1);
		apb(1'b1, `CTBS_IDX_TS_HIGH, ~t0);
		rd(`CTBS_IDX_TS_HIGH, t0[7:0]);
		apb(1'b1, `CTBS_IDX_TIE, 7);
		#1 chk(txIrq, 1);
		apb(1'b1, `CTBS_IDX_TIE, 0);
		#1 chk(txIrq, 0);
		load(0, 1, 0, 1);
		apb(1'b1, `CTBS_IDX_ABORT_REQ, 1);
		rd(`CTBS_IDX_ABORT_ACK, 1);
		rd(`CTBS_IDX_TXE, 7);
		load(1, 1, 0, 0);
		fork
			frame(1'b0, 1, 0);
			begin
				wait (txValid);
				apb(1'b1, `CTBS_IDX_ABORT_REQ, 2);
			end
		join
		rd(`CTBS_IDX_ABORT_ACK, 1);
		stop_test;
	end
	initial
	begin
		#50us;
		num_errors++;
		stop_test;
	end
endmodule
bind ctbs_can_tx_buffer_scheduler ctbs_checker_sva chk_i (.*);
